// ===== hw/compare_skip_defines.vh
`ifndef COMPARE_SKIP_DEFINES_VH
`define COMPARE_SKIP_DEFINES_VH

// Opcode upper byte with the access flag masked off
`define OPC_MASK 8'hfe
`define OPC_SKIP_GREATER 8'h64
`define OPC_SKIP_LESS 8'h60
`define ACCESS_FLAG_BIT 8
`define OPC_HI 15
`define OPC_LO 8
`define FADDR_HI 7
`define FADDR_LO 0
`define FADDR_RESET 8'h00
// Subtraction result fields
`define DIFF_BORROW_BIT 8
`define DIFF_HI 7
`define DIFF_LO 0
// Indexed literal offset window upper bound
`define INDEXED_LIMIT 8'h5f
// Phase codes, one-hot
`define PH_Q1 4'h1
`define PH_Q2 4'h2
`define PH_Q3 4'h4
`define PH_Q4 4'h8
`define PH_RESET 4'h1
// Skip cycles left when the skipped word is one or two words long
`define SKIP_ONE 2'h1
`define SKIP_TWO 2'h2
`define SKIP_NONE 2'h0
`define SKIP_DEC 2'h1

`endif

// ===== hw/compare_skip_execute.v
// Operation
// - Greater opcode skips next instruction if byte exceeds working reg.
// - Less opcode skips next instruction if byte is below working reg.
// - Less opcode byte 0110000a; a is bank flag; low byte is address.
// - Unsigned subtraction compare; status flags left untouched.
// - One word; one cycle without skip, two cycles with skip.
// - Skipping a two-word instruction takes three cycles in total.
// - Flag 0: access bank; flag 1: bank select register picks bank.
// - Greater opcode only: flag 0 plus extended set and address up to 95 uses indexed mode.
// - Decode Q1, read strobe Q3, compare at the Q4 edge, no write; skip cycles all idle.
`timescale 1ns/10ps
`include "compare_skip_defines.vh"

module compare_skip_execute (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_sys_rst,
  // Instruction cycle
  input wire i_phase_adv,
  input wire [15:0] i_instr,
  input wire i_next_is_two_word,
  input wire i_ext_set_en,
  // Operands
  input wire [7:0] i_file_data,
  input wire [7:0] i_working_register,
  // Address selection
  output reg [7:0] o_file_addr,
  output reg o_use_access_bank,
  output reg o_use_bank_select_register,
  output reg o_use_indexed_offset,
  output reg o_file_read,
  // Execution effects
  output reg o_file_write,
  output reg o_working_write,
  output reg o_status_write,
  output reg o_skip_taken,
  output reg o_nop_cycle,
  output reg o_instr_done,
  output reg [3:0] o_phase
);

  // ==========================================================
  // Decode
  wire [7:0] opc_hi = i_instr[`OPC_HI:`OPC_LO] & `OPC_MASK;
  wire is_greater = (opc_hi == `OPC_SKIP_GREATER);
  wire is_less = (opc_hi == `OPC_SKIP_LESS);
  wire access_flag = i_instr[`ACCESS_FLAG_BIT];
  wire [7:0] faddr = i_instr[`FADDR_HI:`FADDR_LO];

  // ==========================================================
  // Phase codes, one-hot
  localparam PH_Q1 = `PH_Q1;
  localparam PH_Q2 = `PH_Q2;
  localparam PH_Q3 = `PH_Q3;
  localparam PH_Q4 = `PH_Q4;
  localparam PH_RESET = `PH_RESET;

  // ==========================================================
  // Unsigned subtract; borrow gives less, nonzero no-borrow greater
  wire [8:0] diff;
  assign diff = {1'b0, i_file_data} -
    {1'b0, i_working_register};
  wire borrow = diff[`DIFF_BORROW_BIT];
  wire nonzero = |diff[`DIFF_HI:`DIFF_LO];
  wire greater = !borrow && nonzero;
  wire less = borrow;

  // ==========================================================
  // State
  reg [3:0] phase_reg;
  reg [3:0] phase_next;
  reg [1:0] skip_left_reg;
  reg [1:0] skip_left_next;
  reg is_greater_reg;
  reg is_less_reg;
  reg two_word_reg;
  reg file_read_next;
  reg skip_taken_next;
  reg instr_done_next;
  reg nop_cycle_next;

  // ==========================================================
  // Q phase sequencer
  always @* begin
    case (phase_reg)
      PH_Q1: phase_next = PH_Q2;
      PH_Q2: phase_next = PH_Q3;
      PH_Q3: phase_next = PH_Q4;
      PH_Q4: phase_next = PH_Q1;
      default: phase_next = PH_RESET;
    endcase
  end

  // Phase advance qualifiers
  wire in_skip = (skip_left_reg != `SKIP_NONE);
  wire adv_q1 = i_phase_adv && (phase_reg == PH_Q1);
  wire adv_q2 = i_phase_adv && (phase_reg == PH_Q2);
  wire adv_q4 = i_phase_adv && (phase_reg == PH_Q4);
  // Skip cycles discard whatever sits on the instruction bus
  wire take_instr = adv_q1 && !in_skip;
  wire is_compare = is_greater_reg || is_less_reg;
  wire cond_met = (is_greater_reg && greater) ||
    (is_less_reg && less);

  // ==========================================================
  // Skip counter
  // Operands only matter at the Q4 edge; earlier values are ignored
  always @* begin
    skip_left_next = skip_left_reg;
    if (adv_q4) begin
      if (in_skip) begin
        skip_left_next = skip_left_reg - `SKIP_DEC;
      end else if (cond_met) begin
        // One cycle per skipped word
        skip_left_next = two_word_reg ?
          `SKIP_TWO : `SKIP_ONE;
      end
    end
  end

  // ==========================================================
  // Strobe next values
  always @* begin
    file_read_next = 1'b0;
    skip_taken_next = 1'b0;
    instr_done_next = 1'b0;
    nop_cycle_next = o_nop_cycle;
    if (adv_q2) begin
      file_read_next = !in_skip && is_compare;
    end
    if (adv_q4) begin
      skip_taken_next = !in_skip &&
        (skip_left_next != `SKIP_NONE);
      instr_done_next = (skip_left_next == `SKIP_NONE);
      // Level spans every Q phase of the skip cycles
      nop_cycle_next = (skip_left_next != `SKIP_NONE);
    end
  end

  // ==========================================================
  // Phase and skip registers
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      phase_reg <= PH_RESET;
      o_phase <= PH_RESET;
      skip_left_reg <= `SKIP_NONE;
    end else if (i_phase_adv) begin
      phase_reg <= phase_next;
      o_phase <= phase_next;
      skip_left_reg <= skip_left_next;
    end
  end

  // ==========================================================
  // Opcode latch
  // Decode in Q1; the opcode must survive until the Q4 decision
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      is_greater_reg <= 1'b0;
      is_less_reg <= 1'b0;
      two_word_reg <= 1'b0;
    end else if (take_instr) begin
      is_greater_reg <= is_greater;
      is_less_reg <= is_less;
      two_word_reg <= i_next_is_two_word;
    end
  end

  // ==========================================================
  // Address selection outputs
  // Held through skip cycles so the bank logic sees no glitch
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_file_addr <= `FADDR_RESET;
      o_use_access_bank <= 1'b0;
      o_use_bank_select_register <= 1'b0;
      o_use_indexed_offset <= 1'b0;
    end else if (take_instr) begin
      o_file_addr <= faddr;
      o_use_access_bank <= !access_flag;
      o_use_bank_select_register <= access_flag;
      // Indexed mode only for the greater compare
      o_use_indexed_offset <= is_greater && !access_flag &&
        i_ext_set_en && (faddr <= `INDEXED_LIMIT);
    end
  end

  // ==========================================================
  // Execution strobes
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_file_read <= 1'b0;
      o_skip_taken <= 1'b0;
      o_instr_done <= 1'b0;
      o_nop_cycle <= 1'b0;
      o_file_write <= 1'b0;
      o_working_write <= 1'b0;
      o_status_write <= 1'b0;
    end else begin
      o_file_read <= file_read_next;
      o_skip_taken <= skip_taken_next;
      o_instr_done <= instr_done_next;
      o_nop_cycle <= nop_cycle_next;
      // Compares never write anything
      o_file_write <= 1'b0;
      o_working_write <= 1'b0;
      o_status_write <= 1'b0;
    end
  end

endmodule

// ===== sim/compare_skip_props.sv
`timescale 1ns/10ps
// ====
// Port checks
module compare_skip_props (
  input wire i_sys_clk, i_sys_rst,
  input wire [7:0] o_file_addr,
  input wire [3:0] o_phase,
  input wire o_use_access_bank, o_use_bank_select_register,
  input wire o_use_indexed_offset, o_file_read, o_file_write,
  input wire o_working_write, o_status_write, o_skip_taken,
  input wire o_nop_cycle, o_instr_done
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  a_file_kept: assert property (!o_file_write)
    else $error("file write");
  a_work_kept: assert property (!o_working_write)
    else $error("W write");
  a_flags_kept: assert property (!o_status_write)
    else $error("flag write");
  a_skip_nop: assert property (o_skip_taken |->
    o_nop_cycle && !o_instr_done ##1 o_nop_cycle) else $error("skip");
  a_read_q3: assert property (o_file_read |->
    o_phase == 4'h4 && !o_nop_cycle) else $error("read");
  a_bank_pick: assert property (o_use_bank_select_register |->
    !o_use_access_bank) else $error("bank");
  a_index_win: assert property (o_use_indexed_offset |->
    o_use_access_bank && o_file_addr <= 8'h5f) else $error("index");
  a_phase_hot: assert property ($onehot(o_phase))
    else $error("phase");
  a_nop_done: assert property ($fell(o_nop_cycle) |-> o_instr_done)
    else $error("nop end");
  cover property (o_skip_taken);
  cover property (o_use_indexed_offset);
  cover property (o_nop_cycle [*8]);
endmodule

// ===== sim/test_compare_skip_execute.sv
`timescale 1ns/10ps
module test_compare_skip_execute;
  logic i_sys_clk = 0, i_sys_rst = 1, i_phase_adv = 0, sk = 0;
  logic i_next_is_two_word = 0, i_ext_set_en = 0;
  logic [15:0] i_instr = 0, exp_q[$];
  logic [7:0] i_file_data = 0, i_working_register = 0, o_file_addr;
  logic o_use_access_bank, o_use_bank_select_register;
  logic o_use_indexed_offset, o_file_read, o_file_write, o_working_write;
  logic o_status_write, o_skip_taken, o_nop_cycle, o_instr_done;
  logic [3:0] o_phase, ncnt = 0;
  logic [1:0] rcnt = 0, exp_rd[$];
  logic [7:0] ops[6] = '{8'h64, 8'h65, 8'h60, 8'h61, 8'h62, 8'h24};
  int error_cnt = 0, checked = 0;
  compare_skip_execute compare_skip_execute_i (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_phase_adv(i_phase_adv),
    .i_instr(i_instr),
    .i_next_is_two_word(i_next_is_two_word),
    .i_ext_set_en(i_ext_set_en),
    .i_file_data(i_file_data),
    .i_working_register(i_working_register),
    .o_file_addr(o_file_addr),
    .o_use_access_bank(o_use_access_bank),
    .o_use_bank_select_register(o_use_bank_select_register),
    .o_use_indexed_offset(o_use_indexed_offset),
    .o_file_read(o_file_read),
    .o_file_write(o_file_write),
    .o_working_write(o_working_write),
    .o_status_write(o_status_write),
    .o_skip_taken(o_skip_taken),
    .o_nop_cycle(o_nop_cycle),
    .o_instr_done(o_instr_done),
    .o_phase(o_phase)
  );
  always #50 i_sys_clk = ~i_sys_clk;
  task give_verdict;
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task cmp(input logic [15:0] e, s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH result exp %h got %h", e, s);
    end
  endtask
  task cmp_read(input logic [1:0] e, s);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH file_read exp %h got %h", e, s);
    end
  endtask
  // ====
  // Driver: skip length fixed by the cycle counts
  task run(input logic [7:0] hi, f, d, w, input logic two, ext);
    logic s;
    s = hi[7:1] == 7'h32 ? d > w : hi[7:1] == 7'h30 ? d < w : 1'b0;
    exp_q.push_back({s, s ? (two ? 4'h8 : 4'h4) : 4'h0,
      hi == 8'h64 && ext && f <= 8'h5f, hi[0], !hi[0], f});
    exp_rd.push_back((hi[7:1] == 7'h32 || hi[7:1] == 7'h30) ? 2'h1 : 2'h0);
    i_instr = {hi, f};
    i_file_data = d;
    i_working_register = w;
    i_next_is_two_word = two;
    i_ext_set_en = ext;
    repeat (s ? (two ? 12 : 8) : 4) @(negedge i_sys_clk);
    $display("op %h done", hi);
  endtask
  // ====
  // Watcher
  always @(negedge i_sys_clk) begin
    if (o_nop_cycle) ncnt = ncnt + 4'h1;
    if (o_skip_taken) sk = 1;
    if (o_file_read) rcnt = rcnt + 2'h1;
    if (o_instr_done) begin
      cmp_read(exp_rd.pop_front(), rcnt);
      rcnt = 0;
      cmp(exp_q.pop_front(), {sk, ncnt, o_use_indexed_offset,
        o_use_bank_select_register, o_use_access_bank, o_file_addr});
      sk = 0;
      ncnt = 0;
    end
  end
  initial begin
    void'($urandom(75));
    repeat (4) @(negedge i_sys_clk);
    i_sys_rst = 0;
    i_phase_adv = 1;
    run(8'h64, 8'h5f, 8'h81, 8'h80, 1, 1);
    run(8'h64, 8'h60, 8'h80, 8'h80, 0, 1);
    run(8'h60, 8'h10, 8'h00, 8'hff, 1, 0);
    repeat (60) run(ops[$urandom % 6], 8'($urandom), 8'($urandom % 4),
      8'($urandom % 4), 1'($urandom), 1'($urandom));
    repeat (4) @(negedge i_sys_clk);
    // Every queued expectation must have been matched by a done pulse
    if (exp_q.size() != 0 || exp_rd.size() != 0) error_cnt++;
    give_verdict;
  end
  initial begin
    #300000;
    error_cnt++;
    give_verdict;
  end
endmodule
bind compare_skip_execute compare_skip_props compare_skip_props_i (
  .i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst),
  .o_file_addr(o_file_addr),
  .o_phase(o_phase),
  .o_use_access_bank(o_use_access_bank),
  .o_use_bank_select_register(o_use_bank_select_register),
  .o_use_indexed_offset(o_use_indexed_offset),
  .o_file_read(o_file_read),
  .o_file_write(o_file_write),
  .o_working_write(o_working_write),
  .o_status_write(o_status_write),
  .o_skip_taken(o_skip_taken),
  .o_nop_cycle(o_nop_cycle),
  .o_instr_done(o_instr_done)
);
